// File: dmpc_pkg.sv
package dmpc_pkg;

  // -------------------------------------------------------------------
  // Register indices and byte address width
  // -------------------------------------------------------------------
  localparam logic [7:0] IDX_DISP_MODE = 8'h70;
  localparam logic [7:0] IDX_SPEC_FX = 8'h71;
  localparam logic [7:0] IDX_PIN_CFG = 8'h72;
  localparam logic [7:0] IDX_STATUS = 8'h73;
  localparam logic [7:0] IDX_LUT_ADDR = 8'h74;
  localparam logic [7:0] IDX_LUT_DATA = 8'h75;
  localparam int ADDR_W = 10;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int DM_BLANK = 7;
  localparam int DM_DITH_DIS = 6;
  localparam int DM_HW_INV = 5;
  localparam int DM_SW_INV = 4;
  localparam int FX_WORD_SWAP = 7;
  localparam int FX_BYTE_SWAP = 6;
  localparam int FX_OVL_EN = 4;
  localparam int PC_PIN_DIR = 0;
  localparam int PC_PIN_IN_EN = 7;
  localparam int PC_PANEL_LO = 8;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_DISP_MODE = 8'h00;
  localparam logic [7:0] RST_SPEC_FX = 8'h00;
  localparam logic [9:0] RST_PIN_CFG = 10'h001;

  // -------------------------------------------------------------------
  // Encodings
  // -------------------------------------------------------------------
  localparam logic [2:0] BPP_1 = 3'h0;
  localparam logic [2:0] BPP_2 = 3'h1;
  localparam logic [2:0] BPP_4 = 3'h2;
  localparam logic [2:0] BPP_8 = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;
  localparam logic [1:0] PANEL_PASSIVE = 2'h0;
  localparam logic [1:0] PANEL_ACTIVE = 2'h1;
  localparam logic [1:0] PANEL_PIN_REUSE_A = 2'h2;
  localparam logic [1:0] PANEL_PIN_REUSE_B = 2'h3;

  // -------------------------------------------------------------------
  // Sizes
  // -------------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int PIX_W = 18;
  localparam int FIFO_DEPTH = 16;
  localparam int LUT_DEPTH = 256;

endpackage

// File: dmpc_top.sv
// Functional notes
// RQ1: blank clear lets pixel pipeline run normally
// RQ2: blank set stops pipeline, pixel outputs zero
// RQ3: dither disable bit gates passive panel dithering
// RQ4: hardware invert enable hands inversion to pin
// RQ5: pin inversion unavailable on pin-reusing panels
// RQ6: hardware invert clear ignores the pin
// RQ7: hardware invert set follows pin level
// RQ8: system straps, enables input, sets pin direction
// RQ9: hardware invert clear uses software bit
// RQ10: software invert bit one inverts video
// RQ11: software inverts where pin path unavailable
// RQ12: inversion applied after the lookup table
// RQ13: depth field serves main and overlay windows
// RQ14: depth codes one to sixteen, rest reserved
// RQ15: depths up to eight use lookup table
// RQ16: sixteen bpp bypasses the lookup table
// RQ17: word swap exchanges 16-bit halves
// RQ18: byte swap exchanges bytes within halves
// RQ19: rotation field selects display orientation
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Synchronous FIFO
// ---------------------------------------------------------------------
module dmpc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_cnt;
  logic rdy_ff;

  // Ready is loaded from the next fill level, so the port comes from a
  // register and still refuses the push that would overflow.
  assign in_ready_o = rdy_ff;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem[rd_ptr_ff];
  assign level_o = cnt_ff;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != FULL);
    end
  end
endmodule

// ---------------------------------------------------------------------
// Display mode and pixel control
// ---------------------------------------------------------------------
module dmpc_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Fetched display words
  input wire logic fetch_valid_i,
  input wire logic [31:0] fetch_data_i,
  output logic fetch_ready_o,
  // Pins
  input wire logic general_io_pin_zero_i,
  input wire logic config_strap_three_i,
  // Panel pixel output
  output logic [17:0] pixel_data_o,
  output logic pixel_valid_o,
  input wire logic pixel_ready_i,
  // Mode outputs
  output logic dither_active_o,
  output logic [1:0] rotate_mode_o,
  output logic overlay_window_en_o,
  output logic [2:0] overlay_window_depth_o
);

  // -------------------------------------------------------------------
  // Registers and declarations
  // -------------------------------------------------------------------
  logic [7:0] disp_mode_ff;
  logic [7:0] spec_fx_ff;
  logic [9:0] pin_cfg_ff;
  logic [7:0] lut_addr_ff;
  logic [17:0] lut_mem [dmpc_pkg::LUT_DEPTH];
  logic dp_wr_ff;
  logic dp_rd_ff;
  logic [7:0] dp_idx_ff;
  logic hready_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_val;
  logic addr_take;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic strap_meta_ff;
  logic strap_sync_ff;
  logic strap_ff;
  logic strap_done_ff;
  logic [1:0] strap_age_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [31:0] fifo_word;
  logic [4:0] fifo_level;
  logic [31:0] sw_word;
  logic [4:0] pix_idx_ff;
  logic [2:0] shift;
  logic [4:0] last_idx;
  logic bpp_ok;
  logic [31:0] raw_word;
  logic [15:0] raw_pix;
  logic [17:0] color;
  logic hw_path_ok;
  logic invert;
  logic pipe_run;
  logic stall;
  logic [17:0] pixel_data_ff;
  logic pixel_valid_ff;
  logic dither_ff;
  logic [1:0] rotate_ff;
  logic ovl_en_ff;
  logic [2:0] ovl_depth_ff;

  // -------------------------------------------------------------------
  // Bus slave
  // -------------------------------------------------------------------
  // Reads take one wait state so that a read right behind a write sees
  // the written value without a forwarding path.
  assign addr_take = hsel_i & hready_i & htrans_i[1];

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dp_wr_ff <= 1'b0;
      dp_rd_ff <= 1'b0;
      dp_idx_ff <= 8'h00;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end
    else
    begin
      if (hready_i)
      begin
        dp_wr_ff <= addr_take & hwrite_i;
        dp_rd_ff <= addr_take & ~hwrite_i;
        dp_idx_ff <= haddr_i[9:2];
      end
      hready_ff <= ~(addr_take & ~hwrite_i);
      if (dp_rd_ff && !hready_ff)
      begin
        hrdata_ff <= rd_val;
      end
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (dp_idx_ff)
      dmpc_pkg::IDX_DISP_MODE: rd_val = {24'h000000, disp_mode_ff};
      dmpc_pkg::IDX_SPEC_FX: rd_val = {24'h000000, spec_fx_ff};
      dmpc_pkg::IDX_PIN_CFG: rd_val = {22'h000000, pin_cfg_ff};
      dmpc_pkg::IDX_STATUS:
        rd_val = {24'h000000, pixel_valid_ff, disp_mode_ff[7],
                  strap_ff, fifo_level};
      dmpc_pkg::IDX_LUT_ADDR: rd_val = {24'h000000, lut_addr_ff};
      dmpc_pkg::IDX_LUT_DATA: rd_val = {14'h0000, lut_mem[lut_addr_ff]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      disp_mode_ff <= dmpc_pkg::RST_DISP_MODE;
      spec_fx_ff <= dmpc_pkg::RST_SPEC_FX;
      pin_cfg_ff <= dmpc_pkg::RST_PIN_CFG;
      lut_addr_ff <= 8'h00;
    end
    else if (dp_wr_ff)
    begin
      case (dp_idx_ff)
        dmpc_pkg::IDX_DISP_MODE: disp_mode_ff <= hwdata_i[7:0] & 8'hF7;
        dmpc_pkg::IDX_SPEC_FX: spec_fx_ff <= hwdata_i[7:0] & 8'hD3;
        dmpc_pkg::IDX_PIN_CFG: pin_cfg_ff <= hwdata_i[9:0] & 10'h381;
        dmpc_pkg::IDX_LUT_ADDR: lut_addr_ff <= hwdata_i[7:0];
        dmpc_pkg::IDX_LUT_DATA: lut_addr_ff <= lut_addr_ff + 8'h01;
        default: lut_addr_ff <= lut_addr_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (dp_wr_ff && dp_idx_ff == dmpc_pkg::IDX_LUT_DATA)
    begin
      lut_mem[lut_addr_ff] <= hwdata_i[17:0];
    end
  end

  // -------------------------------------------------------------------
  // Pin synchronisers and strap capture
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= general_io_pin_zero_i;
      pin_sync_ff <= pin_meta_ff;
      strap_meta_ff <= config_strap_three_i;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // The strap is taken once, on the third edge after reset release, when
  // the second synchroniser stage holds a settled copy of the pin.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_ff <= 1'b0;
      strap_done_ff <= 1'b0;
      strap_age_ff <= 2'h0;
    end
    else
    begin
      strap_age_ff <= {strap_age_ff[0], 1'b1};
      if (strap_age_ff[1] && !strap_done_ff)
      begin
        strap_ff <= strap_sync_ff;
        strap_done_ff <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // Fetch FIFO and word swapping
  // -------------------------------------------------------------------
  dmpc_fifo #(
    .WIDTH(dmpc_pkg::WORD_W),
    .DEPTH(dmpc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fetch_valid_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fetch_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_word),
    .level_o(fifo_level)
  );

  assign fetch_ready_o = fifo_in_ready;

  always_comb
  begin
    sw_word = fifo_word;
    if (spec_fx_ff[dmpc_pkg::FX_WORD_SWAP])
    begin
      sw_word = {sw_word[15:0], sw_word[31:16]}; // RQ17
    end
    if (spec_fx_ff[dmpc_pkg::FX_BYTE_SWAP])
    begin
      sw_word = {sw_word[23:16], sw_word[31:24],
                 sw_word[7:0], sw_word[15:8]}; // RQ18
    end
  end

  // -------------------------------------------------------------------
  // Pixel unpacking and colour mapping
  // -------------------------------------------------------------------
  // One depth setting serves both windows, so the overlay simply mirrors
  // the main depth field.
  always_comb
  begin
    bpp_ok = 1'b1;
    case (disp_mode_ff[2:0]) // RQ13 RQ14
      dmpc_pkg::BPP_1: shift = 3'h0;
      dmpc_pkg::BPP_2: shift = 3'h1;
      dmpc_pkg::BPP_4: shift = 3'h2;
      dmpc_pkg::BPP_8: shift = 3'h3;
      dmpc_pkg::BPP_16: shift = 3'h4;
      default:
      begin
        shift = 3'h0;
        bpp_ok = 1'b0;
      end
    endcase
  end

  assign last_idx = 5'(6'd32 >> shift) - 5'd1;
  assign raw_word = sw_word >> (6'(pix_idx_ff) << shift);

  always_comb
  begin
    raw_pix = raw_word[15:0] & 16'((17'h00002 << ((6'd1 << shift) - 6'd1))
                                   - 17'h00001);
    if (shift == 3'h4)
    begin
      color = {raw_pix[15:11], raw_pix[15], raw_pix[10:5],
               raw_pix[4:0], raw_pix[4]}; // RQ16
    end
    else
    begin
      color = lut_mem[raw_pix[7:0]]; // RQ15
    end
  end

  // Pin control only counts when the strap, the input enable and the
  // input direction are all in place and the panel leaves the pin free.
  assign hw_path_ok = strap_ff & pin_cfg_ff[dmpc_pkg::PC_PIN_IN_EN] // RQ8
                    & ~pin_cfg_ff[dmpc_pkg::PC_PIN_DIR]
                    & ~pin_cfg_ff[dmpc_pkg::PC_PANEL_LO + 1]; // RQ5

  always_comb
  begin
    if (disp_mode_ff[dmpc_pkg::DM_HW_INV]) // RQ4
    begin
      invert = hw_path_ok & pin_sync_ff; // RQ7
    end
    else
    begin
      invert = disp_mode_ff[dmpc_pkg::DM_SW_INV]; // RQ6 RQ9 RQ10 RQ11
    end
  end

  assign stall = pixel_valid_ff & ~pixel_ready_i;
  assign pipe_run = ~disp_mode_ff[dmpc_pkg::DM_BLANK] & bpp_ok // RQ1
                  & fifo_out_valid & ~stall;
  assign fifo_pop = pipe_run & (pix_idx_ff == last_idx);

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pix_idx_ff <= 5'h00;
    end
    else if (disp_mode_ff[dmpc_pkg::DM_BLANK] || fifo_pop)
    begin
      pix_idx_ff <= 5'h00;
    end
    else if (pipe_run)
    begin
      pix_idx_ff <= pix_idx_ff + 5'h01;
    end
  end

  // -------------------------------------------------------------------
  // Panel output stage
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pixel_data_ff <= 18'h00000;
      pixel_valid_ff <= 1'b0;
    end
    else if (disp_mode_ff[dmpc_pkg::DM_BLANK])
    begin
      pixel_data_ff <= 18'h00000; // RQ2
      pixel_valid_ff <= 1'b0;
    end
    else if (pipe_run)
    begin
      pixel_data_ff <= color ^ {18{invert}}; // RQ12
      pixel_valid_ff <= 1'b1;
    end
    else if (!stall)
    begin
      pixel_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dither_ff <= 1'b0;
      rotate_ff <= 2'h0;
      ovl_en_ff <= 1'b0;
      ovl_depth_ff <= 3'h0;
    end
    else
    begin
      dither_ff <= (pin_cfg_ff[9:8] == dmpc_pkg::PANEL_PASSIVE)
                 & ~disp_mode_ff[dmpc_pkg::DM_DITH_DIS]; // RQ3
      rotate_ff <= spec_fx_ff[1:0]; // RQ19
      ovl_en_ff <= spec_fx_ff[dmpc_pkg::FX_OVL_EN];
      ovl_depth_ff <= disp_mode_ff[2:0]; // RQ13
    end
  end

  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o = 1'b0;
  assign pixel_data_o = pixel_data_ff;
  assign pixel_valid_o = pixel_valid_ff;
  assign dither_active_o = dither_ff;
  assign rotate_mode_o = rotate_ff;
  assign overlay_window_en_o = ovl_en_ff;
  assign overlay_window_depth_o = ovl_depth_ff;

endmodule

// File: dmpc_checker.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Port checker for the display mode block
// ---------------------------------------------------------------------
module dmpc_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  // Pixel and mode outputs
  input wire logic [17:0] pixel_data_o,
  input wire logic pixel_valid_o,
  input wire logic pixel_ready_i,
  input wire logic dither_active_o,
  input wire logic [1:0] rotate_mode_o,
  input wire logic [2:0] overlay_window_depth_o
);
  logic taken;
  logic wr_pend_ff;
  logic [9:0] addr_ff;
  logic [7:0] dm_ff;
  logic [7:0] fx_ff;
  logic [9:0] pc_ff;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  assign taken = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 10'h000;
    end
    else if (hready_i)
    begin
      wr_pend_ff <= taken && hwrite_i;
      addr_ff <= haddr_i[9:0];
    end
  end

  // Shadow copies of the registers let outputs be tied to what was written.
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dm_ff <= dmpc_pkg::RST_DISP_MODE;
      fx_ff <= dmpc_pkg::RST_SPEC_FX;
      pc_ff <= dmpc_pkg::RST_PIN_CFG;
    end
    else if (wr_pend_ff && hready_i)
    begin
      if (addr_ff == 10'h1C0)
        dm_ff <= hwdata_i[7:0] & 8'hF7;
      if (addr_ff == 10'h1C4)
        fx_ff <= hwdata_i[7:0] & 8'hD3;
      if (addr_ff == 10'h1C8)
        pc_ff <= hwdata_i[9:0] & 10'h381;
    end
  end

  read_wait_a: assert property (
    taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not wait exactly one cycle");
  write_nowait_a: assert property (taken && hwrite_i |=> hreadyout_o)
    else $error("write inserted a wait state");
  read_back_a: assert property (
    taken && !hwrite_i && haddr_i[9:0] == 10'h1C0
    |-> ##2 hrdata_o == {24'h0, dm_ff})
    else $error("display mode read back differs");
  unmapped_zero_a: assert property (
    taken && !hwrite_i && haddr_i[9:0] > 10'h1D4
    |-> ##2 hreadyout_o && hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  blank_zero_a: assert property (
    dm_ff[7] && $past(dm_ff[7]) |-> !pixel_valid_o && pixel_data_o == 18'h0)
    else $error("pixel output active while blanked");
  stall_hold_a: assert property (
    pixel_valid_o && !pixel_ready_i && !dm_ff[7]
    |=> pixel_valid_o && $stable(pixel_data_o))
    else $error("stalled pixel not held");
  dither_mode_a: assert property (
    $past(resetn_i) && $stable(dm_ff) && $stable(pc_ff)
    |-> dither_active_o == (pc_ff[9:8] == 2'h0 && !dm_ff[6]))
    else $error("dither output wrong");
  rotate_pass_a: assert property (
    $past(resetn_i) && $stable(fx_ff) |-> rotate_mode_o == fx_ff[1:0])
    else $error("rotation output wrong");
  depth_share_a: assert property (
    $past(resetn_i) && $stable(dm_ff)
    |-> overlay_window_depth_o == dm_ff[2:0])
    else $error("overlay depth differs from main depth");

  cover property (taken && !hwrite_i);
  cover property (pixel_valid_o && !pixel_ready_i);
  cover property (dm_ff[7] && dm_ff[2:0] == 3'h4);
endmodule

bind dmpc_top dmpc_checker i_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .pixel_data_o(pixel_data_o),
  .pixel_valid_o(pixel_valid_o), .pixel_ready_i(pixel_ready_i),
  .dither_active_o(dither_active_o), .rotate_mode_o(rotate_mode_o),
  .overlay_window_depth_o(overlay_window_depth_o)
);

// File: dmpc_panel.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Panel model
// ---------------------------------------------------------------------
module dmpc_panel (
  // Clock
  input wire logic clk_i,
  // Pixel input
  input wire logic [17:0] pix_i,
  input wire logic valid_i,
  output logic ready_o,
  // Bench side
  input wire logic slow_i,
  output logic got_o,
  output logic [17:0] got_pix_o
);
  initial
  begin
    ready_o = 1'b1;
    got_o = 1'b0;
    got_pix_o = 18'h0;
  end

  // A slow panel drops ready at random, so held pixels get exercised.
  always @(posedge clk_i)
  begin
    ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
    got_o <= valid_i && ready_o;
    got_pix_o <= pix_i;
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------------
module tb;
  localparam logic [9:0] A_DM = 10'h1C0;
  localparam logic [9:0] A_FX = 10'h1C4;
  localparam logic [9:0] A_PC = 10'h1C8;
  logic clk;
  logic resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic fvalid;
  logic [31:0] fdata;
  logic fready;
  logic pin;
  logic strap;
  logic ovl;
  logic resp;
  logic [17:0] pix;
  logic pvalid;
  logic pready;
  logic dith;
  logic [1:0] rot;
  logic [2:0] depth;
  logic slow;
  logic got;
  logic [17:0] got_pix;
  logic rd_dp;
  logic [17:0] lut_m [16];
  logic [31:0] fill [16];
  logic [17:0] px_q [$];
  logic [31:0] rd_q [$];
  int bad_count;
  int compares;

  dmpc_top i_dut (
    .core_clk_i(clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(resp), .fetch_valid_i(fvalid),
    .fetch_data_i(fdata), .fetch_ready_o(fready),
    .general_io_pin_zero_i(pin), .config_strap_three_i(strap),
    .pixel_data_o(pix), .pixel_valid_o(pvalid), .pixel_ready_i(pready),
    .dither_active_o(dith), .rotate_mode_o(rot),
    .overlay_window_en_o(ovl), .overlay_window_depth_o(depth)
  );

  dmpc_panel i_panel (
    .clk_i(clk), .pix_i(pix), .valid_i(pvalid), .ready_o(pready),
    .slow_i(slow), .got_o(got), .got_pix_o(got_pix)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Result watcher
  // ---------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (got)
      check({14'h0, got_pix}, px_q.size() ? px_q.pop_front() : '1);
    if (rd_dp && hready)
    begin
      check(hrdata, rd_q.pop_front());
      check({31'h0, resp}, 32'h0);
    end
    rd_dp <= hready ? hsel && htrans[1] && !hwrite : rd_dp;
  end

  task automatic ahb(input logic [9:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    ahb(a, 1'b0, 32'h0);
  endtask

  task automatic feed(input logic [31:0] w);
    fvalid <= 1'b1;
    fdata <= w;
    @(posedge clk);
    while (fready !== 1'b1)
      @(posedge clk);
  endtask

  task automatic expect_word(input logic [31:0] w, input logic [7:0] dm,
    input logic [7:0] fx, input logic [17:0] inv);
    int b;
    logic [15:0] v;
    b = 1 << dm[2:0];
    if (fx[6])
      w = {w[23:16], w[31:24], w[7:0], w[15:8]};
    if (fx[7])
      w = {w[15:0], w[31:16]};
    for (int k = 0; k < 32 / b; k++)
    begin
      v = 16'(w >> (k * b)) & 16'((1 << b) - 1);
      if (b == 16)
        px_q.push_back({v[15:11], v[15], v[10:0], v[4]} ^ inv);
      else
        px_q.push_back(lut_m[v[3:0]] ^ inv);
    end
  endtask

  task automatic drain;
    for (int i = 0; i < 2000 && px_q.size() > 0; i++)
      @(posedge clk);
    check(32'(px_q.size()), 32'h0);
    repeat (3)
      @(posedge clk);
  endtask

  task automatic run(input logic [7:0] dm, input logic [7:0] fx,
    input logic [9:0] pc, input logic p);
    logic [31:0] w;
    logic [17:0] inv;
    pin <= p;
    slow <= ~slow;
    ahb(A_PC, 1'b1, {22'h0, pc});
    ahb(A_FX, 1'b1, {24'h0, fx});
    ahb(A_DM, 1'b1, {24'h0, dm});
    inv = {18{dm[5] ? p && strap && pc[7] && !pc[0] && !pc[9]
              : dm[4]}};
    for (int n = 0; n < 3; n++)
    begin
      w = $urandom();
      if (dm[2:0] == 3'h3)
        w = w & 32'h0F0F0F0F;
      expect_word(w, dm, fx, inv);
      feed(w);
    end
    fvalid <= 1'b0;
    drain();
  endtask

  initial
  begin
    {hsel, hwrite, fvalid, pin, slow, resetn, rd_dp} = 7'h0;
    strap = 1'b1;
    {haddr, hwdata, fdata, htrans} = 98'h0;
    void'($urandom(32'h970F754E));
    repeat (4)
      @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(A_DM, 32'h0);
    rd(A_FX, 32'h0);
    rd(A_PC, 32'h1);
    ahb(10'h3F0, 1'b1, 32'hFFFFFFFF);
    rd(10'h3F0, 32'h0);
    ahb(A_DM, 1'b1, 32'h000000FF);
    rd(A_DM, 32'h000000F7);
    ahb(A_FX, 1'b1, 32'hFFFFFFFF);
    rd(A_FX, 32'h000000D3);
    for (int i = 0; i < 8; i++)
    begin
      ahb(A_PC, 1'b1, {22'h0, i[1:0], 8'h80});
      ahb(A_FX, 1'b1, {27'h0, i[2], 2'h0, i[1:0]});
      ahb(A_DM, 1'b1, {24'h0, 1'b1, i[2], 3'h0, i[2:0]});
      repeat (2)
        @(posedge clk);
      check({31'h0, dith}, {31'h0, i[1:0] == 2'h0 && !i[2]});
      check({30'h0, rot}, {30'h0, i[1:0]});
      check({29'h0, depth}, {29'h0, i[2:0]});
      check({31'h0, ovl}, {31'h0, i[2]});
    end
    ahb(10'h1D0, 1'b1, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      lut_m[i] = 18'($urandom());
      ahb(10'h1D4, 1'b1, {14'h0, lut_m[i]});
    end
    for (int d = 0; d < 5; d++)
      run({5'h0, d[2:0]}, 8'h00, 10'h180, 1'b0);
    run(8'h04, 8'h40, 10'h180, 1'b0);
    run(8'h04, 8'h80, 10'h180, 1'b0);
    run(8'h04, 8'hC0, 10'h180, 1'b0);
    run(8'h13, 8'hC0, 10'h180, 1'b1);
    run(8'h34, 8'h00, 10'h180, 1'b1);
    run(8'h33, 8'h00, 10'h180, 1'b0);
    run(8'h24, 8'h00, 10'h280, 1'b1);
    run(8'h24, 8'h00, 10'h181, 1'b1);
    run(8'h14, 8'h00, 10'h380, 1'b1);
    // Blanking keeps the buffer from draining, so it can be filled.
    ahb(A_DM, 1'b1, 32'h00000084);
    for (int n = 0; n < 16; n++)
    begin
      fill[n] = $urandom();
      feed(fill[n]);
    end
    fvalid <= 1'b0;
    repeat (3)
      @(posedge clk);
    check({31'h0, fready}, 32'h0);
    check({13'h0, pvalid, pix}, 32'h0);
    // A reserved depth code unblanked must still send no pixels.
    ahb(A_DM, 1'b1, 32'h00000005);
    repeat (3)
      @(posedge clk);
    check({30'h0, pvalid, fready}, 32'h0);
    for (int n = 0; n < 16; n++)
      expect_word(fill[n], 8'h04, 8'h00, 18'h0);
    slow <= 1'b1;
    ahb(A_DM, 1'b1, 32'h00000004);
    drain();
    // A second reset with the strap low must keep pin control off.
    strap <= 1'b0;
    resetn <= 1'b0;
    repeat (2)
      @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(A_DM, 32'h0);
    run(8'h34, 8'h00, 10'h180, 1'b1);
    end_of_test();
  end

  initial
  begin
    repeat (40000)
      @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
